// *** flag_monitor.sv ***
// Downstream monitor of the four overrange flags.
// Assumes level flags; in single mode both channels count.
`timescale 1ns/100ps
module flag_monitor (
   input  wire logic a_hi_i,
   input  wire logic a_lo_i,
   input  wire logic b_hi_i,
   input  wire logic b_lo_i,
   output logic      hi_seen_o,
   output logic      lo_seen_o
);
   assign hi_seen_o = a_hi_i | b_hi_i;
   assign lo_seen_o = a_lo_i | b_lo_i;
endmodule

// *** overrange_detect_and_sample_marker.sv ***
// Overrange detection and timestamp marking on two 8-bit sample streams.
// Assumes samples arrive synchronous to core_clk_i, two per channel per clock.
`timescale 1ns/100ps
module overrange_detect_and_sample_marker #(
   parameter int SYNC_N = ovr_pkg::SYNC_STAGES
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [7:0]  haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Sample streams: [7:0] first (rising) sample, [15:8] second (falling)
   input  wire logic [15:0] chan_a_data_i,
   input  wire logic [15:0] chan_b_data_i,
   input  wire logic        trigger_in_p,
   input  wire logic        trigger_in_n,
   output logic [15:0]      chan_a_data_o,
   output logic [15:0]      chan_b_data_o,
   output logic             chan_a_flag_hi_o,
   output logic             chan_a_flag_lo_o,
   output logic             chan_b_flag_hi_o,
   output logic             chan_b_flag_lo_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [6:0] magnitude(input logic [7:0] s);
      logic [7:0] neg;
      neg = 8'h00 - s;
      if (s == 8'h80) begin
         magnitude = 7'h7F;
      end else if (s[7]) begin
         magnitude = neg[6:0];
      end else begin
         magnitude = s[6:0];
      end
   endfunction

   // Second sample only counts in single mode
   function automatic logic pair_hit(input logic [15:0] d, input logic single, input logic [6:0] thr);
      pair_hit = (magnitude(d[7:0]) >= thr) || (single && (magnitude(d[15:8]) >= thr));
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [2:0]  hold_sel_reg,  hold_sel_next;
   logic        ts_en_reg,     ts_en_next;
   logic        single_reg,    single_next;
   logic [6:0]  high_threshold_reg, high_threshold_next;
   logic [6:0]  low_threshold_reg,  low_threshold_next;
   ovr_pkg::bus_state_t bus_reg, bus_next;
   logic [7:0]  addr_reg,      addr_next;
   logic        wr_reg,        wr_next;
   logic [31:0] rdata_reg,     rdata_next;
   logic [SYNC_N-1:0] trig_sync_reg, trig_sync_next;
   logic        ready_reg;
   logic        resp_reg;
   logic [3:0]  hit_reg,       hit_next;
   logic [15:0] a_out_reg,     a_out_next;
   logic [15:0] b_out_reg,     b_out_next;
   logic [3:0]  flags;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   always_comb begin
      bus_next            = bus_reg;
      addr_next           = addr_reg;
      wr_next             = wr_reg;
      rdata_next          = rdata_reg;
      hold_sel_next       = hold_sel_reg;
      ts_en_next          = ts_en_reg;
      single_next         = single_reg;
      high_threshold_next = high_threshold_reg;
      low_threshold_next  = low_threshold_reg;
      if (bus_reg == ovr_pkg::BUS_DATA && wr_reg) begin
         case (addr_reg)
            ovr_pkg::CTRL_OFS: begin
               hold_sel_next = hwdata_i[ovr_pkg::CTRL_HOLD_LSB +: ovr_pkg::CTRL_HOLD_W];
               ts_en_next    = hwdata_i[ovr_pkg::CTRL_TS_BIT];
               single_next   = hwdata_i[ovr_pkg::CTRL_MODE_BIT];
            end
            ovr_pkg::THRESH_OFS: begin
               high_threshold_next = hwdata_i[ovr_pkg::THR_HI_LSB +: ovr_pkg::THR_W];
               low_threshold_next  = hwdata_i[ovr_pkg::THR_LO_LSB +: ovr_pkg::THR_W];
            end
            default: begin
            end
         endcase
      end
      bus_next = ovr_pkg::BUS_IDLE;
      if (hsel_i && hready_i && htrans_i[1]) begin
         bus_next  = ovr_pkg::BUS_DATA;
         addr_next = {haddr_i[7:2], 2'b00};
         wr_next   = hwrite_i;
         // Read data latched at address phase, so reads take no wait state
         // Next values let a read right behind a write see the new contents
         case ({haddr_i[7:2], 2'b00})
            ovr_pkg::CTRL_OFS:   rdata_next = {27'h0, single_next, ts_en_next, hold_sel_next};
            ovr_pkg::THRESH_OFS: rdata_next = {17'h0, low_threshold_next, 1'b0, high_threshold_next};
            ovr_pkg::STATUS_OFS: rdata_next = {27'h0, trig_sync_reg[SYNC_N-1], flags};
            default:             rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_reg            <= ovr_pkg::BUS_IDLE;
         addr_reg           <= 8'h00;
         wr_reg             <= 1'b0;
         rdata_reg          <= 32'h0;
         hold_sel_reg       <= ovr_pkg::HOLD_SEL_RST;
         ts_en_reg          <= 1'b0;
         single_reg         <= 1'b0;
         high_threshold_reg <= ovr_pkg::THR_HI_RST;
         low_threshold_reg  <= ovr_pkg::THR_LO_RST;
         ready_reg          <= 1'b1;
         resp_reg           <= 1'b0;
      end else begin
         ready_reg          <= 1'b1;
         resp_reg           <= 1'b0;
         bus_reg            <= bus_next;
         addr_reg           <= addr_next;
         wr_reg             <= wr_next;
         rdata_reg          <= rdata_next;
         hold_sel_reg       <= hold_sel_next;
         ts_en_reg          <= ts_en_next;
         single_reg         <= single_next;
         high_threshold_reg <= high_threshold_next;
         low_threshold_reg  <= low_threshold_next;
      end
   end

   assign hrdata_o    = rdata_reg;
   assign hreadyout_o = ready_reg;
   assign hresp_o     = resp_reg;

   // ----------------------------------------
   // Trigger synchroniser
   // ----------------------------------------
   // Fixed depth keeps mark-to-sample latency deterministic
   always_comb begin
      trig_sync_next = {trig_sync_reg[SYNC_N-2:0], trigger_in_p & ~trigger_in_n};
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_sync_reg <= '0;
      end else begin
         trig_sync_reg <= trig_sync_next;
      end
   end

   // ----------------------------------------
   // Detection and output stream
   // ----------------------------------------
   always_comb begin
      hit_next[0] = pair_hit(chan_a_data_i, single_reg, high_threshold_reg);
      hit_next[1] = pair_hit(chan_a_data_i, single_reg, low_threshold_reg);
      hit_next[2] = pair_hit(chan_b_data_i, single_reg, high_threshold_reg);
      hit_next[3] = pair_hit(chan_b_data_i, single_reg, low_threshold_reg);
      a_out_next  = chan_a_data_i;
      b_out_next  = chan_b_data_i;
      if (ts_en_reg) begin
         a_out_next[0] = trig_sync_reg[SYNC_N-1];
         a_out_next[8] = trig_sync_reg[SYNC_N-1];
         b_out_next[0] = trig_sync_reg[SYNC_N-1];
         b_out_next[8] = trig_sync_reg[SYNC_N-1];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hit_reg   <= 4'h0;
         a_out_reg <= 16'h0000;
         b_out_reg <= 16'h0000;
      end else begin
         hit_reg   <= hit_next;
         a_out_reg <= a_out_next;
         b_out_reg <= b_out_next;
      end
   end

   assign chan_a_data_o = a_out_reg;
   assign chan_b_data_o = b_out_reg;

   genvar g;
   for (g = 0; g < 4; g++) begin : g_flag
      ovr_flag_hold #(
         .CNT_W      (ovr_pkg::HOLD_CNT_W)
      ) u_hold (
         .core_clk_i (core_clk_i),
         .rst_n_i    (rst_n_i),
         .hit_i      (hit_reg[g]),
         .hold_sel_i (hold_sel_reg),
         .flag_o     (flags[g])
      );
   end

   // Single mode: far side ORs A and B flags per threshold
   assign chan_a_flag_hi_o = flags[0];
   assign chan_a_flag_lo_o = flags[1];
   assign chan_b_flag_hi_o = flags[2];
   assign chan_b_flag_lo_o = flags[3];

endmodule

// *** ovr_flag_hold.sv ***
// One overrange flag with its hold counter.
// Assumes the hit input is already registered in the core clock domain.
`timescale 1ns/100ps
module ovr_flag_hold #(
   parameter int CNT_W = 11
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             hit_i,
   input  wire logic [2:0]       hold_sel_i,
   output logic                  flag_o
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             flag_reg;
   logic             flag_next;

   always_comb begin
      cnt_next  = cnt_reg;
      flag_next = flag_reg;
      if (hit_i) begin
         // Full reload so the flag drops only after a whole quiet interval
         cnt_next  = CNT_W'(ovr_pkg::HOLD_BASE_CYC << hold_sel_i);
         flag_next = 1'b1;
      end else if (cnt_reg > CNT_W'(1)) begin
         cnt_next = cnt_reg - CNT_W'(1);
      end else begin
         cnt_next  = '0;
         flag_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg  <= '0;
         flag_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;

endmodule

// *** ovr_pkg.sv ***
// Constants shared by the overrange detector and its register slave.
// Assumes a single 40 MHz core clock and an AHB-Lite master with word-only access.
//
// Functional notes
// - Samples are signed two's complement; negative when inverting input is higher.
// - Dual mode takes one sample per clock; single mode takes two per clock.
// - Magnitude is seven bits; -128 saturates to 127.
// - Flag sets when magnitude meets or exceeds its threshold, and clears once the hold expires.
// - Both channels share one pair of thresholds in dual mode.
// - Each channel drives one flag per threshold, high then low.
// - Hold length is 8 times two to the selection, 8 to 1024 cycles.
// - Timestamp is inactive and emits nothing unless enabled.
// - With timestamp enabled, each sample LSB carries the trigger status.
// - Asynchronous trigger is sampled to align with its analog sample.
package ovr_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] THRESH_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_HOLD_LSB = 0;
   localparam int CTRL_HOLD_W   = 3;
   localparam int CTRL_TS_BIT   = 3;
   localparam int CTRL_MODE_BIT = 4;
   localparam int THR_HI_LSB    = 0;
   localparam int THR_LO_LSB    = 8;
   localparam int THR_W         = 7;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [2:0] HOLD_SEL_RST = 3'h0;
   localparam logic [6:0] THR_HI_RST   = 7'h7F;
   localparam logic [6:0] THR_LO_RST   = 7'h40;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int HOLD_BASE_CYC = 8;
   localparam int HOLD_CNT_W    = 11;
   localparam int SYNC_STAGES   = 3;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DATA = 2'b01
   } bus_state_t;

endpackage

// *** ovr_sva.sv ***
// Port checker for the overrange block.
// Assumes register writes only arrive over the bus seen here.
`timescale 1ns/100ps
module ovr_sva (
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        hsel_i,
   input wire logic [7:0]  haddr_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic        hready_i,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic [15:0] chan_a_data_i,
   input wire logic [15:0] chan_b_data_i,
   input wire logic [15:0] chan_a_data_o,
   input wire logic [15:0] chan_b_data_o,
   input wire logic        chan_a_flag_hi_o,
   input wire logic        chan_a_flag_lo_o,
   input wire logic        chan_b_flag_hi_o,
   input wire logic        chan_b_flag_lo_o
);
   logic       wr_reg, sgl_reg, ts_reg, ha_hi, ha_lo, hb_hi, hb_lo;
   logic [7:0] addr_reg;
   logic [6:0] hi_reg, lo_reg;
   function automatic logic [6:0] mag(input logic [7:0] s);
      return s == 8'h80 ? 7'h7F : (s[7] ? 7'(-s) : s[6:0]);
   endfunction
   function automatic logic hit(input logic [15:0] d, input logic [6:0] t, input logic sgl);
      return mag(d[7:0]) >= t || (sgl && mag(d[15:8]) >= t);
   endfunction
   assign ha_hi = hit(chan_a_data_i, hi_reg, sgl_reg);
   assign ha_lo = hit(chan_a_data_i, lo_reg, sgl_reg);
   assign hb_hi = hit(chan_b_data_i, hi_reg, sgl_reg);
   assign hb_lo = hit(chan_b_data_i, lo_reg, sgl_reg);
   // ----------------------------------------
   // Register shadow, updated on the write data phase
   // ----------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         sgl_reg <= 1'b0;
         ts_reg <= 1'b0;
         hi_reg <= ovr_pkg::THR_HI_RST;
         lo_reg <= ovr_pkg::THR_LO_RST;
      end else begin
         wr_reg <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
         addr_reg <= haddr_i;
         if (wr_reg && addr_reg == ovr_pkg::CTRL_OFS) begin
            sgl_reg <= hwdata_i[ovr_pkg::CTRL_MODE_BIT];
            ts_reg <= hwdata_i[ovr_pkg::CTRL_TS_BIT];
         end
         if (wr_reg && addr_reg == ovr_pkg::THRESH_OFS) begin
            hi_reg <= hwdata_i[6:0];
            lo_reg <= hwdata_i[14:8];
         end
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence a_lo_hit_s; ha_lo; endsequence
   ready_always_a: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
   a_hi_set_a: assert property (ha_hi |-> ##2 chan_a_flag_hi_o) else $error("a hi flag missed");
   a_lo_set_a: assert property (a_lo_hit_s |-> ##2 chan_a_flag_lo_o) else $error("a lo flag missed");
   b_hi_set_a: assert property (hb_hi |-> ##2 chan_b_flag_hi_o) else $error("b hi flag missed");
   b_lo_cause_a: assert property ($rose(chan_b_flag_lo_o) |-> $past(hb_lo, 2)) else $error("b lo flag no cause");
   a_hi_hold_a: assert property ($rose(chan_a_flag_hi_o) |-> chan_a_flag_hi_o [*8]) else $error("hold short");
   data_pass_a: assert property (chan_a_data_o[7:1] == $past(chan_a_data_i[7:1])) else $error("a data bad");
   b_pass_a: assert property (chan_b_data_o[15:9] == $past(chan_b_data_i[15:9])) else $error("b data bad");
   ts_off_a: assert property (!ts_reg && !$past(ts_reg) |-> chan_a_data_o[0] == $past(chan_a_data_i[0]))
      else $error("lsb marked while off");
endmodule
bind overrange_detect_and_sample_marker ovr_sva chk (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .chan_a_data_i, .chan_b_data_i, .chan_a_data_o,
   .chan_b_data_o, .chan_a_flag_hi_o, .chan_a_flag_lo_o, .chan_b_flag_hi_o, .chan_b_flag_lo_o);

// *** tb_top.sv ***
// Testbench: bus tasks and sample pulses against the overrange block.
// Assumes a zero-wait slave; hreadyout feeds hready back.
`timescale 1ns/100ps
module tb_top;
   logic        core_clk_i, rst_n_i, hsel_i, hwrite_i, trg_p, trg_n, hrdy, hresp, a_hi, a_lo, b_hi, b_lo, hi_s, lo_s;
   logic [7:0]  haddr_i;
   logic [1:0]  htrans_i;
   logic [31:0] hwdata_i, hrdata, rd;
   logic [15:0] a_in, b_in, a_out, b_out;
   logic [7:0]  smp [7] = '{8'h90, 8'h80, 8'h7F, 8'h6F, 8'h00, 8'hE0, 8'h1F};
   logic [1:0]  exp2 [7] = '{2'b11, 2'b11, 2'b11, 2'b01, 2'b00, 2'b01, 2'b00};
   int          error_cnt, tests_run, n;
   overrange_detect_and_sample_marker uut (.core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .chan_a_data_i(a_in), .chan_b_data_i(b_in), .trigger_in_p(trg_p), .trigger_in_n(trg_n),
      .chan_a_data_o(a_out), .chan_b_data_o(b_out), .chan_a_flag_hi_o(a_hi), .chan_a_flag_lo_o(a_lo),
      .chan_b_flag_hi_o(b_hi), .chan_b_flag_lo_o(b_lo));
   flag_monitor mon (.a_hi_i(a_hi), .a_lo_i(a_lo), .b_hi_i(b_hi), .b_lo_i(b_lo), .hi_seen_o(hi_s), .lo_seen_o(lo_s));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= wr;
      htrans_i <= 2'b10;
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'b00;
      hwdata_i <= d;
      do @(posedge core_clk_i); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic pulse(input logic [15:0] a, input logic [15:0] b);
      a_in <= a;
      b_in <= b;
      @(posedge core_clk_i);
      a_in <= 16'h0000;
      b_in <= 16'h0000;
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   initial begin
      #500000;
      error_cnt++;
      complete_run();
   end
   initial begin
      {rst_n_i, hsel_i, hwrite_i, trg_p, trg_n, haddr_i, htrans_i, hwdata_i, a_in, b_in} = '0;
      repeat (4) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      bus(0, ovr_pkg::CTRL_OFS, 0);
      chk(rd, 32'h0, "ctrl reset");
      bus(0, ovr_pkg::THRESH_OFS, 0);
      chk(rd, 32'({1'b0, ovr_pkg::THR_LO_RST, 1'b0, ovr_pkg::THR_HI_RST}), "thresh reset");
      bus(1, 8'h0C, 32'hFFFF_FFFF);
      bus(0, 8'h0C, 0);
      chk(rd, 32'h0, "unmapped");
      bus(1, ovr_pkg::THRESH_OFS, 32'h0000_2070);
      bus(0, ovr_pkg::THRESH_OFS, 0);
      chk(rd, 32'h0000_2070, "thresh rw");
      $display("test registers done");
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 7; i++) begin
            pulse(c ? 16'h0 : 16'(smp[i]), c ? 16'(smp[i]) : 16'h0);
            chk(32'({a_hi, a_lo, b_hi, b_lo}), c ? 32'(exp2[i]) : 32'({exp2[i], 2'b00}), "magnitude");
            repeat (12) @(posedge core_clk_i);
         end
      $display("test thresholds done");
      for (int s = 0; s < 8; s++) begin
         @(posedge core_clk_i);
         bus(1, ovr_pkg::CTRL_OFS, 32'(s));
         pulse(16'h0080, 16'h0);
         if (s == 0) begin
            @(posedge core_clk_i);
            pulse(16'h0080, 16'h0);
         end
         n = 0;
         // Counts every cycle the flag is seen high, the first one included
         while (a_hi === 1'b1 && n < 2000) begin
            n++;
            @(posedge core_clk_i);
            #1;
         end
         chk(32'(n), 32'(ovr_pkg::HOLD_BASE_CYC << s), "hold length");
      end
      $display("test hold done");
      for (int m = 0; m < 2; m++) begin
         @(posedge core_clk_i);
         bus(1, ovr_pkg::CTRL_OFS, m ? 32'h10 : 32'h0);
         pulse(16'h0, 16'h8000);
         chk(32'({a_hi, a_lo, b_hi, b_lo, hi_s, lo_s}), m ? 32'h0F : 32'h0, "second edge sample");
         repeat (12) @(posedge core_clk_i);
      end
      $display("test mode done");
      bus(1, ovr_pkg::CTRL_OFS, 0);
      trg_p <= 1'b1;
      repeat (6) @(posedge core_clk_i);
      #1;
      chk(32'({a_out, b_out}), 32'h0, "mark while off");
      @(posedge core_clk_i);
      bus(1, ovr_pkg::CTRL_OFS, 32'h08);
      repeat (6) @(posedge core_clk_i);
      #1;
      chk(32'({a_out, b_out}), 32'h0101_0101, "mark on");
      @(posedge core_clk_i);
      trg_p <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(32'(a_out[0]), 32'h1, "mark early");
      @(posedge core_clk_i);
      #1;
      chk(32'(a_out[0]), 32'h0, "mark latency");
      $display("test timestamp done");
      complete_run();
   end
endmodule
